/* rtl/dual_shift_reg.sv */
// Dual static serial shift register driven by one external clock pin
`default_nettype none
// Function
// - One clock pin; complement phase made inside
// - Clock rising captures serial input into stage
// - Output changes only on a pop, at either clock level
// - Clock falling advances one bit per cycle while the buffer has room or out_ready is high
// - Stages hold their value statically
// - Two identical independent halves share clock
// - Each half is 16 or 32 stages
// - Any rate to stop; contents kept halted
module dual_shift_reg
   import sreg_pkg::*;
#(
   parameter int unsigned STAGES = STAGES_SHORT
) (
   // System
   input  wire logic core_clk,
   input  wire logic arst_n,
   // Link pins
   input  wire logic shift_clk,
   input  wire pair_t ser_in,
   // Output stream
   output logic      out_valid,
   input  wire logic out_ready,
   output pair_t     ser_out,
   // Back-pressure toward the source
   output logic      shift_ready
);

   // ---------------------------------------------------------------
   // Check clocking
   // ---------------------------------------------------------------
   // Checks sleep in reset; data stages stay unknown until filled anyway
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic  clk_s1_q, clk_s2_q, clk_s3_q;
   pair_t din_s1_q, din_s2_q;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_s1_q <= 1'b0;
         clk_s2_q <= 1'b0;
         clk_s3_q <= 1'b0;
         din_s1_q <= '0;
         din_s2_q <= '0;
      end else begin
         clk_s1_q <= shift_clk;
         clk_s2_q <= clk_s1_q;
         clk_s3_q <= clk_s2_q;
         din_s1_q <= ser_in;
         din_s2_q <= din_s1_q;
      end
   end

   // ---------------------------------------------------------------
   // Phase decode
   // ---------------------------------------------------------------
   phase_t phase;
   wire    clk_rise;
   wire    clk_fall;
   wire    buf_in_ready;

   // Complement phase is derived here, so only one clock pin exists
   assign phase    = clk_s2_q ? PH_ACTIVE : PH_IDLE;
   assign clk_rise = clk_s2_q & ~clk_s3_q;
   // A fall with the buffer full and out_ready low is lost; shift_ready warns the source
   assign clk_fall = ~clk_s2_q & clk_s3_q & buf_in_ready;

   a_single_phase: assert property (!(clk_rise && clk_fall))
      else $error("both phases in one cycle");
   a_rise_high: assert property (clk_rise |-> phase == PH_ACTIVE)
      else $error("rise seen while clock low");
   a_fall_low: assert property (clk_fall |-> phase == PH_IDLE)
      else $error("fall seen while clock high");
   a_sync_clk: assert property (clk_rise |-> $past(shift_clk, 2))
      else $error("rise not from the pin");

   // ---------------------------------------------------------------
   // Master latches and slave chains, one per half
   // ---------------------------------------------------------------
   // No reset on data: a real register powers up with random content
   pair_t              master_q;
   logic [STAGES-1:0]  chain_a_q;
   logic [STAGES-1:0]  chain_b_q;

   always_ff @(posedge core_clk) begin
      if (clk_rise) begin
         master_q <= din_s2_q;
      end
   end
   // Enable-only flop: a stopped pin clock loads nothing, so a halt keeps it

   a_capture_rise: assert property (clk_rise |=> master_q == $past(din_s2_q))
      else $error("rise did not capture input");
   a_capture_pin: assert property (clk_rise |=> master_q == $past(ser_in, 3))
      else $error("captured bit is not the pin value");
   a_halt_keep: assert property (!clk_rise |=> $stable(master_q))
      else $error("master changed with no rise");

   always_ff @(posedge core_clk) begin
      if (clk_fall) begin
         chain_a_q <= {chain_a_q[STAGES-2:0], master_q.half_a};
         chain_b_q <= {chain_b_q[STAGES-2:0], master_q.half_b};
      end
   end
   // Without edges nothing loads, so contents stay put at any rate

   a_shift_fall: assert property (clk_fall |=> chain_a_q[0] == $past(master_q.half_a))
      else $error("fall did not shift half a");
   a_shift_half_b: assert property (clk_fall |=> chain_b_q[0] == $past(master_q.half_b))
      else $error("fall did not shift half b");
   a_static_stop: assert property (!clk_fall |=> $stable(chain_a_q) && $stable(chain_b_q))
      else $error("chain changed with no fall");
   a_one_fall: assert property (clk_fall |=> !clk_fall)
      else $error("two shifts from one fall");

   // ---------------------------------------------------------------
   // Stage taps
   // ---------------------------------------------------------------
   pair_t tail;
   assign tail.half_a = chain_a_q[STAGES-1];
   assign tail.half_b = chain_b_q[STAGES-1];

   // ---------------------------------------------------------------
   // Two-entry output buffer
   // ---------------------------------------------------------------
   pair_t      mem_q [BUF_DEPTH];
   logic       wr_q, rd_q;
   logic [1:0] cnt_q;
   wire        push;
   wire        pop;

   assign buf_in_ready = (cnt_q != BUF_FULL) | out_ready;
   // Ready ignores out_ready: the fall lands three cycles after the pin, when the
   // consumer may have stalled, so only a free slot is a promise that holds
   assign shift_ready  = (cnt_q != BUF_FULL);
   assign out_valid    = (cnt_q != BUF_EMPTY);
   assign push         = clk_fall;
   assign pop          = out_valid & out_ready;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         cnt_q <= BUF_EMPTY;
      end else begin
         if (push) begin
            wr_q <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + CNT_ONE;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - CNT_ONE;
         end
      end
   end

   // ---------------------------------------------------------------
   // Buffer checks
   // ---------------------------------------------------------------
   // A refused fall must leave the buffer exactly as it was
   a_ready_full: assert property (cnt_q == BUF_FULL |-> !shift_ready)
      else $error("ready shown with buffer full");
   a_push_count: assert property (push && !pop |=> cnt_q == $past(cnt_q) + CNT_ONE)
      else $error("push did not add a word");
   a_pop_count: assert property (pop && !push |=> cnt_q == $past(cnt_q) - CNT_ONE)
      else $error("pop did not take a word");
   a_swap_count: assert property (push && pop |=> $stable(cnt_q))
      else $error("count moved on push with pop");
   a_drop_hold: assert property (!clk_s2_q && clk_s3_q && !buf_in_ready |=> $stable(cnt_q))
      else $error("refused fall changed the buffer");
   a_valid_hold: assert property (out_valid && !out_ready |=> out_valid)
      else $error("word withdrawn before taken");
   a_empty_idle: assert property (!push && cnt_q == BUF_EMPTY |=> !out_valid)
      else $error("valid with no word");
   a_buf_bound: assert property (cnt_q <= BUF_FULL)
      else $error("buffer overfilled");
   a_tail_push: assert property (push && cnt_q == BUF_EMPTY |=> out_valid)
      else $error("pushed word not visible");

   // Entry written is the bit leaving the chain on this step
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_q] <= tail;
      end
   end

   // ---------------------------------------------------------------
   // Output register
   // ---------------------------------------------------------------
   // Output holds the previous word until a pop, whatever the clock phase
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ser_out <= '0;
      end else if (pop) begin
         ser_out <= mem_q[rd_q];
      end
   end

   a_hold_active: assert property (phase == PH_ACTIVE && !pop |=> $stable(ser_out))
      else $error("output moved while clock high");

   // ---------------------------------------------------------------
   // Scenario covers
   // ---------------------------------------------------------------
   c_shift: cover property (clk_rise ##[1:20] clk_fall);
   c_full: cover property (cnt_q == BUF_FULL);
   c_stall: cover property ((out_valid && !out_ready) [*3]);
   c_swap: cover property (push && pop);
   c_drain: cover property (pop ##1 !out_valid);
endmodule
`default_nettype wire

/* rtl/sreg_pkg.sv */
// Package: stage counts, stream word type and buffer constants for the dual shift register
`default_nettype none
package sreg_pkg;
   localparam int unsigned STAGES_SHORT = 16;
   localparam int unsigned STAGES_LONG  = 32;
   localparam int unsigned BUF_DEPTH    = 2;
   localparam logic [1:0]  BUF_EMPTY    = 2'h0;
   localparam logic [1:0]  BUF_FULL     = 2'h2;
   localparam logic [1:0]  CNT_ONE      = 2'h1;
   localparam logic        SEL_HEAD     = 1'h0;

   // One bit for each half, moved together on a shift step
   typedef struct packed {
      logic half_b;
      logic half_a;
   } pair_t;

   // Phase of the single link clock after sampling
   typedef enum logic [1:0] {
      PH_IDLE   = 2'b00,
      PH_ACTIVE = 2'b01
   } phase_t;
endpackage
`default_nettype wire

/* sim/shift_source.sv */
// Partner model: outside logic driving the shift clock pin and serial data
`default_nettype none
module shift_source
   import sreg_pkg::*;
(
   // System
   input  wire logic core_clk,
   input  wire logic arst_n,
   // Bench control and back-pressure
   input  wire logic halt,
   input  wire logic shift_ready,
   // Chained use: half a's output fed back into half b
   input  wire logic chain_en,
   input  wire pair_t ser_out,
   // Link pins
   output logic      shift_clk,
   output pair_t     ser_in
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 32'hd1f7;
   // Holding high until ready avoids the dropped-fall case
   initial begin
      shift_clk = 1'b0;
      ser_in    = '0;
      wait (arst_n);
      forever begin
         repeat (5) @(posedge core_clk);
         while (halt) @(posedge core_clk);
         shift_clk <= 1'b1;
         repeat (5) @(posedge core_clk);
         while (!shift_ready) @(posedge core_clk);
         shift_clk <= 1'b0;
         @(posedge core_clk);
         ser_in <= chain_en ? {ser_out.half_a, 1'($random(seed))} : 2'($random(seed));
      end
   end
endmodule
`default_nettype wire

/* sim/test_dual_shift_reg.sv */
// Self-checking bench for the dual static shift register
`default_nettype none
module test_dual_shift_reg
   import sreg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned DEPTH = STAGES_SHORT;
   logic  core_clk  = 1'b0;
   logic  arst_n    = 1'b0;
   logic  out_ready = 1'b0;
   logic  halt      = 1'b0;
   logic  pend      = 1'b0;
   logic  chain_en  = 1'b0;
   logic  shift_clk, out_valid, shift_ready;
   pair_t ser_in, ser_out;
   pair_t in_q[$];
   int    seed = 32'hd1f7;
   int    fail_count = 0;
   int    cmp_count = 0;
   int    pops = 0;
   always #5 core_clk = ~core_clk;
   dual_shift_reg #(.STAGES(DEPTH)) i_dual_shift_reg (.core_clk(core_clk), .arst_n(arst_n),
      .shift_clk(shift_clk), .ser_in(ser_in), .out_valid(out_valid), .out_ready(out_ready),
      .ser_out(ser_out), .shift_ready(shift_ready));
   shift_source i_shift_source (.core_clk(core_clk), .arst_n(arst_n), .halt(halt),
      .shift_ready(shift_ready), .chain_en(chain_en), .ser_out(ser_out),
      .shift_clk(shift_clk), .ser_in(ser_in));
   task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("Compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic traffic(input int n);
      repeat (n) begin
         @(posedge core_clk);
         out_ready <= 1'($random(seed));
      end
   endtask
   // ----------------------------------------
   // Reference: one bit per pin fall, STAGES deep
   // ----------------------------------------
   always @(negedge shift_clk) if (arst_n) in_q.push_back(ser_in);
   always @(posedge core_clk) begin
      if (pend) begin
         if (pops >= DEPTH) check("ser_out", ser_out, in_q[pops - DEPTH]);
         pops++;
      end
      pend <= out_valid && out_ready;
   end
   initial begin
      repeat (20) @(posedge core_clk);
      check("valid_rst", {1'b0, out_valid}, 2'h0);
      check("ready_rst", {1'b0, shift_ready}, 2'h1);
      arst_n <= 1'b1;
      traffic(600);
      out_ready <= 1'b0;
      repeat (120) @(posedge core_clk);
      check("ready_full", {1'b0, shift_ready}, 2'h0);
      check("valid_full", {1'b0, out_valid}, 2'h1);
      halt      <= 1'b1;
      out_ready <= 1'b1;
      repeat (300) @(posedge core_clk);
      check("valid_halt", {1'b0, out_valid}, 2'h0);
      halt     <= 1'b0;
      chain_en <= 1'b1;
      traffic(600);
      halt      <= 1'b1;
      out_ready <= 1'b1;
      repeat (100) @(posedge core_clk);
      check("word_count", {1'b0, pops == in_q.size()}, 2'h1);
      conclude();
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      fail_count++;
      conclude();
   end
endmodule
`default_nettype wire
